// ---- common/psm_pkg.sv ----
package psm_pkg;
   // Mode byte codes for the sleep/stop control register
   localparam logic [7:0] SLEEP_CODE = 8'h0F;
   localparam logic [7:0] STOP_CODE  = 8'h5A;
   localparam logic [7:0] CTL_RESET  = 8'h00;

   // Clock control register fields
   localparam int CK_RC_OSC_WATCHDOG_MODE_BIT  = 5;   // rc_watchdog_select
   localparam int CK_WDT_RST_BIT = 4;   // watchdog_reset_select
   localparam int CK_DIV_LSB     = 0;   // prescaler ratio, 4 bits
   localparam int CK_DIV_W       = 4;
   localparam int PRE_W          = 16;

   // Basic interval timer warm-up span
   localparam logic [7:0] BIT_START = 8'h00;
   localparam logic [7:0] BIT_LAST  = 8'hFF;

   // Wake source lines
   localparam int WK_W     = 7;
   localparam int WK_EXT   = 0;   // external interrupt pins
   localparam int WK_EVT   = 1;   // event counter timer
   localparam int WK_RC_WATCHDOG_SELECT = 2;   // rc-oscillated watchdog
   localparam int WK_WATCH = 3;   // watch timer
   localparam int WK_SIO   = 4;   // sync_serial_port
   localparam int WK_UART  = 5;
   localparam int WK_OTHER = 6;   // any other interrupt

   // Peripheral run enables
   localparam int PR_W     = 8;
   localparam int PR_BIT   = 0;
   localparam int PR_WDT   = 1;
   localparam int PR_WATCH = 2;
   localparam int PR_TMR   = 3;
   localparam int PR_EVT   = 4;
   localparam int PR_BUZAD = 5;
   localparam int PR_SIO   = 6;
   localparam int PR_UART  = 7;

   // Controller register map (APB byte addresses)
   localparam logic [7:0] A_SLEEP_STOP_CONTROL_REG  = 8'h00;
   localparam logic [7:0] A_CKCTL = 8'h04;
   localparam logic [7:0] A_CTRL  = 8'h08;
   localparam logic [7:0] A_WAKE  = 8'h0C;
   localparam logic [7:0] A_IEN   = 8'h10;
   localparam logic [7:0] A_STAT  = 8'h14;
   localparam logic [7:0] A_EVT   = 8'h18;

   // Control register bits
   localparam int C_STOP = 0;
   localparam int C_IFLG = 1;
   localparam int C_WATCHDOG_IRQ_ENABLE = 2;
   localparam int C_EVT  = 3;
   localparam int C_WSUB = 4;
   localparam int C_SIOX = 5;
   localparam int C_UARX = 6;

   // Sticky event bits
   localparam int E_RES  = 0;
   localparam int E_VEC  = 1;
   localparam int E_WDV  = 2;
   localparam int E_IRST = 3;

   typedef enum logic [1:0] {PM_RUN, PM_SLEEP, PM_STOP, PM_WARM} psm_mode_t;
endpackage

// ---- common/psm_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface psm_if;
   import psm_pkg::*;
   // Orders from the core side
   logic              sleep_stop_control_reg_wr;
   logic              ckctl_wr;
   logic [7:0]        wr_byte;
   logic              stop_exec;
   logic              i_flag;
   logic              watchdog_irq_enable;
   logic              ec_mode;
   logic              wt_sub;
   logic              sio_ext;
   logic              uart_ext;
   logic [WK_W-1:0]   wake;
   // Answers from the power controller
   logic              cpu_clk_en;
   logic              sys_clk_en;
   logic              periph_clk_en;
   logic              main_osc_en;
   logic [PR_W-1:0]   run_en;
   psm_mode_t         mode;
   logic [7:0]        sleep_stop_control_reg;
   logic [7:0]        ckctl;
   logic [7:0]        bit_cnt;
   logic              resume;
   logic              vector_irq;
   logic              wdt_vector;
   logic              int_reset;

   modport dev (
      input  sleep_stop_control_reg_wr, ckctl_wr, wr_byte, stop_exec, i_flag, watchdog_irq_enable,
             ec_mode, wt_sub, sio_ext, uart_ext, wake,
      output cpu_clk_en, sys_clk_en, periph_clk_en, main_osc_en, run_en, mode,
             sleep_stop_control_reg, ckctl, bit_cnt, resume, vector_irq, wdt_vector, int_reset
   );
   modport core (
      output sleep_stop_control_reg_wr, ckctl_wr, wr_byte, stop_exec, i_flag, watchdog_irq_enable,
             ec_mode, wt_sub, sio_ext, uart_ext, wake,
      input  cpu_clk_en, sys_clk_en, periph_clk_en, main_osc_en, run_en, mode,
             sleep_stop_control_reg, ckctl, bit_cnt, resume, vector_irq, wdt_vector, int_reset
   );
endinterface
`default_nettype wire

// ---- logic/psm_power_ctl.sv ----
// Function
// R1 - Write 0Fh to control enters sleep
// R2 - Stop instruction with 5Ah loaded enters stop
// R3 - Sleep halts CPU clock only
// R4 - Sleep ends on reset or interrupt
// R5 - Reset clears controls; interrupt wake keeps them
// R6 - Flag set vectors; clear resumes next instruction
// R7 - Stop gates oscillator, system, peripheral clocks
// R8 - Stop holds state and next-instruction address
// R9 - Interval timer halts in stop unless RC variant
// R10 - Watchdog, watch timer gating per mode
// R11 - Timers run in sleep; only event counters in stop
// R12 - Buzzer, ADC off; serial only with external clock
// R13 - Stop released by listed wake sources
// R14 - Stop wake counts 00h to FFh, resumes on overflow
// R15 - Software sets prescaler for over 20 ms
// R16 - Control registers written as whole bytes
// R17 - Two idle instructions follow the stop
// R18 - RC select at stop keeps RC oscillator
// R19 - RC variant exits on reset or external interrupt
// R20 - RC watchdog wake vectors or resets per select
// R21 - Reset exit comes up in main active mode
// R22 - Other codes leave run mode, stop ignored; the code keeps run mode instead
`timescale 1ns/1ns
`default_nettype none
module psm_power_ctl
   import psm_pkg::*;
(
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Core side link
   psm_if.dev        lnk
);
   import psm_pkg::*;

   psm_mode_t            state;
   psm_mode_t            next_state;
   logic                 rc_var;
   logic                 wdt_woke;
   logic [PRE_W-1:0]     pre;
   logic                 tick;
   logic                 bit_on;
   logic [WK_W-1:0]      stop_src;
   logic                 stop_wake;
   logic                 warm_done;
   logic                 rst_pulse;

   // Prescaler tap: one tick every 2^ratio cycles
   function automatic logic pre_tick(input logic [PRE_W-1:0] cnt,
                                     input logic [CK_DIV_W-1:0] ratio);
      logic [PRE_W-1:0] mask;
      mask = ~({PRE_W{1'b1}} << ratio);
      return &(cnt | ~mask);
   endfunction

   // Peripheral run enables for a given mode
   function automatic logic [PR_W-1:0] run_map(input psm_mode_t m, input logic rcv,
                                              input logic wsub, input logic ecm,
                                              input logic siox, input logic uarx);
      logic [PR_W-1:0] r;
      r = '1;
      case (m)
         PM_RUN:
         begin
            r = '1;
         end
         PM_SLEEP:
         begin
            r[PR_WDT]   = 1'b0;                  // see R10
            r[PR_WATCH] = 1'b0;
            r[PR_BUZAD] = 1'b0;                  // see R12
            r[PR_SIO]   = siox;
            r[PR_UART]  = uarx;
         end
         default:
         begin
            r[PR_BIT]   = rcv || (m == PM_WARM); // see R9
            r[PR_WDT]   = rcv;                   // see R10
            r[PR_WATCH] = wsub;
            r[PR_TMR]   = 1'b0;                  // see R11
            r[PR_EVT]   = ecm;
            r[PR_BUZAD] = 1'b0;                  // see R12
            r[PR_SIO]   = siox;
            r[PR_UART]  = uarx;
         end
      endcase
      return r;
   endfunction

   assign tick = pre_tick(pre, lnk.ckctl[CK_DIV_LSB +: CK_DIV_W]);
   assign bit_on = lnk.run_en[PR_BIT];                                   // see R9

   // Stop wake sources, each but the external pins qualified by its clocking; RC variant keeps only the pins and the RC watchdog
   always_comb
   begin
      stop_src = '0;
      stop_src[WK_EXT]   = lnk.wake[WK_EXT];                            // see R13
      stop_src[WK_RC_WATCHDOG_SELECT] = lnk.wake[WK_RC_WATCHDOG_SELECT] && rc_var;
      if (!rc_var)
      begin
         stop_src[WK_EVT]   = lnk.wake[WK_EVT] && lnk.ec_mode;
         stop_src[WK_WATCH] = lnk.wake[WK_WATCH] && lnk.wt_sub;
         stop_src[WK_SIO]   = lnk.wake[WK_SIO] && lnk.sio_ext;
         stop_src[WK_UART]  = lnk.wake[WK_UART] && lnk.uart_ext;
      end
   end
   assign stop_wake = |stop_src;                                         // see R19
   assign warm_done = tick && (lnk.bit_cnt == BIT_LAST);                 // see R14

   // Mode sequencing
   always_comb
   begin
      next_state = state;
      case (state)
         PM_RUN:
         begin
            if (lnk.sleep_stop_control_reg_wr && lnk.wr_byte == SLEEP_CODE)
               next_state = PM_SLEEP;                                    // see R1
            else if (lnk.stop_exec && lnk.sleep_stop_control_reg == STOP_CODE && !lnk.sleep_stop_control_reg_wr)
               next_state = PM_STOP;                                     // see R2, R22
         end
         PM_SLEEP:
            if (|lnk.wake)
               next_state = PM_RUN;                                      // see R4
         PM_STOP:
            if (stop_wake)
               next_state = PM_WARM;
         PM_WARM:
            if (warm_done)
               next_state = PM_RUN;
         default:
            next_state = PM_RUN;
      endcase
   end

   // Internal reset from the RC watchdog returns the state to run, as a pin reset does
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state <= PM_RUN;                                                // see R21
      else if (rst_pulse)
         state <= PM_RUN;
      else
         state <= next_state;
   end

   // Control registers: cleared by any reset, kept across interrupt wakes
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lnk.sleep_stop_control_reg  <= CTL_RESET;                                         // see R5
         lnk.ckctl <= CTL_RESET;
      end
      else if (rst_pulse)
      begin
         lnk.sleep_stop_control_reg  <= CTL_RESET;
         lnk.ckctl <= CTL_RESET;
      end
      else
      begin
         // Only whole-byte writes exist on this port, so no partial update
         if (lnk.sleep_stop_control_reg_wr)
            lnk.sleep_stop_control_reg <= lnk.wr_byte;                                     // see R16
         if (lnk.ckctl_wr)
            lnk.ckctl <= lnk.wr_byte;
      end
   end

   // Variant tracks the select bit in run, frozen in power-down so stop entry sees it at once
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rc_var <= 1'b0;
      else if (state == PM_RUN)
         rc_var <= lnk.ckctl[CK_RC_OSC_WATCHDOG_MODE_BIT];                             // see R18
   end

   // Remember whether the watchdog woke us, for the response after warm-up
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         wdt_woke <= 1'b0;
      else if (state == PM_STOP && stop_wake)
         wdt_woke <= stop_src[WK_RC_WATCHDOG_SELECT];
   end

   // Prescaler follows the interval timer gate and freezes with it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         pre <= '0;
      else if (state == PM_STOP && stop_wake)
         pre <= '0;
      else if (bit_on)
         pre <= pre + 1'b1;
   end

   // Basic interval timer; restarts from zero at a stop wake
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         lnk.bit_cnt <= BIT_START;
      else if (state == PM_STOP && stop_wake)
         lnk.bit_cnt <= BIT_START;                                       // see R14
      else if (bit_on && tick)
         lnk.bit_cnt <= lnk.bit_cnt + 1'b1;                              // see R9
   end

   // Wake response pulses: vector when flag set (RC watchdog wake: reset, watchdog vector or resume per selects), else resume in place
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lnk.resume     <= 1'b0;
         lnk.vector_irq <= 1'b0;
         lnk.wdt_vector <= 1'b0;
         rst_pulse      <= 1'b0;
      end
      else
      begin
         lnk.resume     <= 1'b0;
         lnk.vector_irq <= 1'b0;
         lnk.wdt_vector <= 1'b0;
         rst_pulse      <= 1'b0;
         if ((state == PM_SLEEP && |lnk.wake) || (state == PM_WARM && warm_done))
         begin
            if (!lnk.i_flag)
               lnk.resume <= 1'b1;                                       // see R6
            else if (state == PM_WARM && rc_var && wdt_woke)
            begin
               if (lnk.ckctl[CK_WDT_RST_BIT])
                  rst_pulse <= 1'b1;                                     // see R20
               else if (lnk.watchdog_irq_enable)
                  lnk.wdt_vector <= 1'b1;
               else
                  lnk.resume <= 1'b1;
            end
            else
               lnk.vector_irq <= 1'b1;
         end
      end
   end
   assign lnk.int_reset = rst_pulse;

   // Clock gating and run enables, registered from the next mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lnk.cpu_clk_en    <= 1'b1;
         lnk.sys_clk_en    <= 1'b1;
         lnk.periph_clk_en <= 1'b1;
         lnk.main_osc_en   <= 1'b1;
         lnk.run_en        <= '1;
         lnk.mode          <= PM_RUN;
      end
      else
      begin
         // CPU clock off holds the core, so its PC stays past the stop
         lnk.cpu_clk_en    <= (next_state == PM_RUN);                    // see R3, R8
         lnk.sys_clk_en    <= (next_state == PM_RUN) || (next_state == PM_SLEEP);
         lnk.periph_clk_en <= (next_state == PM_RUN) || (next_state == PM_SLEEP); // see R7
         lnk.main_osc_en   <= (next_state != PM_STOP);
         lnk.run_en        <= run_map(next_state, rc_var, lnk.wt_sub, lnk.ec_mode,
                                      lnk.sio_ext, lnk.uart_ext);        // see R11
         lnk.mode          <= next_state;
      end
   end
endmodule
`default_nettype wire

// ---- logic/psm_core_side.sv ----
`timescale 1ns/1ns
`default_nettype none
module psm_core_side
   import psm_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Link to the power controller
   psm_if.core              lnk
);
   import psm_pkg::*;

   logic             wr_acc;
   logic             rd_acc;
   logic             mapped;
   logic [6:0]       ctrl;
   logic [WK_W-1:0]  ien;
   logic [3:0]       evt;
   logic [3:0]       evt_set;
   logic [31:0]      next_rdata;

   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   assign pready  = 1'b1;
   assign mapped  = paddr inside {A_SLEEP_STOP_CONTROL_REG, A_CKCTL, A_CTRL, A_WAKE, A_IEN, A_STAT, A_EVT};
   assign pslverr = psel && penable && !mapped;

   // Register writes become byte strobes toward the controller
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         lnk.sleep_stop_control_reg_wr   <= 1'b0;
         lnk.ckctl_wr  <= 1'b0;
         lnk.wr_byte   <= 8'h00;
         lnk.stop_exec <= 1'b0;
         lnk.wake      <= '0;
      end
      else
      begin
         lnk.sleep_stop_control_reg_wr   <= wr_acc && paddr == A_SLEEP_STOP_CONTROL_REG;
         lnk.ckctl_wr  <= wr_acc && paddr == A_CKCTL;
         lnk.wr_byte   <= pwdata[7:0];
         // A stopped core cannot issue another stop
         lnk.stop_exec <= wr_acc && paddr == A_CTRL && pwdata[C_STOP] && lnk.cpu_clk_en;
         // Only enabled interrupts may wake the device
         lnk.wake      <= (wr_acc && paddr == A_WAKE) ? (pwdata[WK_W-1:0] & ien) : '0;
      end
   end

   // Level controls and interrupt enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= '0;
         ien  <= '0;
      end
      else
      begin
         if (wr_acc && paddr == A_CTRL)
            ctrl <= {pwdata[6:1], 1'b0};
         if (wr_acc && paddr == A_IEN)
            ien <= pwdata[WK_W-1:0];
      end
   end
   assign lnk.i_flag              = ctrl[C_IFLG];
   assign lnk.watchdog_irq_enable = ctrl[C_WATCHDOG_IRQ_ENABLE];
   assign lnk.ec_mode             = ctrl[C_EVT];
   assign lnk.wt_sub              = ctrl[C_WSUB];
   assign lnk.sio_ext             = ctrl[C_SIOX];
   assign lnk.uart_ext            = ctrl[C_UARX];

   // Sticky wake events, write one to clear; a new event wins over the clear
   assign evt_set = {lnk.int_reset, lnk.wdt_vector, lnk.vector_irq, lnk.resume};
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         evt <= '0;
      else if (wr_acc && paddr == A_EVT)
         evt <= (evt & ~pwdata[3:0]) | evt_set;
      else
         evt <= evt | evt_set;
   end

   // Read mux
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (paddr)
         A_SLEEP_STOP_CONTROL_REG:  next_rdata = {24'h00_0000, lnk.sleep_stop_control_reg};
         A_CKCTL: next_rdata = {24'h00_0000, lnk.ckctl};
         A_CTRL:  next_rdata = {25'h000_0000, ctrl};
         A_IEN:   next_rdata = {25'h000_0000, ien};
         A_STAT:  next_rdata = {8'h00, lnk.bit_cnt, lnk.run_en, 2'b00, lnk.mode,
                                lnk.main_osc_en, lnk.periph_clk_en, lnk.sys_clk_en,
                                lnk.cpu_clk_en};
         A_EVT:   next_rdata = {28'h000_0000, evt};
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup phase so it stands through the access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (psel && !penable && !pwrite)
         prdata <= next_rdata;
   end
endmodule
`default_nettype wire

// ---- bench/psm_check_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
module psm_check
   import psm_pkg::*;
(
   // Clock and reset
   input wire logic            pclk,
   input wire logic            presetn,
   // Orders from the core side
   input wire logic            sleep_stop_control_reg_wr,
   input wire logic [7:0]      wr_byte,
   input wire logic            i_flag,
   input wire logic [WK_W-1:0] wake,
   // Answers of the controller
   input wire logic            cpu_clk_en,
   input wire logic            sys_clk_en,
   input wire logic            periph_clk_en,
   input wire logic            main_osc_en,
   input wire logic [PR_W-1:0] run_en,
   input wire psm_mode_t       mode,
   input wire logic [7:0]      sleep_stop_control_reg,
   input wire logic [7:0]      ckctl,
   input wire logic [7:0]      bit_cnt,
   input wire logic            resume,
   input wire logic            vector_irq,
   input wire logic            int_reset
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // A mode write lands on the state edge, the registered outputs on that same edge
   sequence sleep_req;
      sleep_stop_control_reg_wr && wr_byte == SLEEP_CODE && mode == PM_RUN;
   endsequence
   sequence other_req;
      sleep_stop_control_reg_wr && wr_byte != SLEEP_CODE && mode == PM_RUN;
   endsequence
   sequence warm_end;
      mode == PM_WARM ##1 mode == PM_RUN;
   endsequence

   sleep_entry_a:
   assert property (sleep_req |-> ##2 mode == PM_SLEEP) else $error("sleep not entered");
   code_ignore_a:
   assert property (other_req |-> ##2 mode == PM_RUN) else $error("other code left run");
   sleep_clk_a:
   assert property (mode == PM_SLEEP |-> !cpu_clk_en && sys_clk_en && periph_clk_en
      && main_osc_en) else $error("sleep clock gating wrong");
   stop_clk_a:
   assert property (mode == PM_STOP |-> !cpu_clk_en && !sys_clk_en && !periph_clk_en
      && !main_osc_en) else $error("stop clock gating wrong");
   sleep_gate_a:
   assert property (mode == PM_SLEEP |-> run_en[PR_BIT] && run_en[PR_TMR] && !run_en[PR_WDT]
      && !run_en[PR_WATCH] && !run_en[PR_BUZAD]) else $error("sleep run enables wrong");
   stop_gate_a:
   assert property (mode == PM_STOP |-> !run_en[PR_BUZAD] && !run_en[PR_TMR]
      && run_en[PR_BIT] == ckctl[CK_RC_OSC_WATCHDOG_MODE_BIT]) else $error("stop run enables wrong");
   stop_hold_a:
   assert property (mode == PM_STOP |-> $stable(sleep_stop_control_reg) && $stable(ckctl))
      else $error("control changed in stop");
   wake_reply_a:
   assert property (mode == PM_SLEEP && wake != '0 |-> ##1 resume != vector_irq
      && vector_irq == $past(i_flag)) else $error("sleep wake reply wrong");
   stop_warm_a:
   assert property (mode == PM_STOP && wake[WK_EXT] |-> ##2 mode == PM_WARM)
      else $error("stop wake did not warm up");
   rc_refuse_a:
   assert property (mode == PM_STOP && ckctl[CK_RC_OSC_WATCHDOG_MODE_BIT] && wake == 7'h08
      |-> ##2 mode == PM_STOP) else $error("watch wake left rc stop");
   warm_count_a:
   assert property (warm_end |-> $past(bit_cnt) == BIT_LAST)
      else $error("warm-up ended early");
   int_reset_a:
   assert property (int_reset |-> ##2 mode == PM_RUN && sleep_stop_control_reg == CTL_RESET
      && ckctl == CTL_RESET) else $error("internal reset incomplete");
endmodule
`default_nettype wire

// ---- bench/power_saving_mode_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module power_saving_mode_control_test;
   import psm_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] rd;
   logic        err;
   int          fail_count;
   int          n_compared;
   int          wsrc [5] = '{WK_EXT, WK_EVT, WK_WATCH, WK_SIO, WK_UART};

   psm_if lnk ();
   psm_core_side i_psm_core_side (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
   psm_power_ctl i_psm_power_ctl (.pclk(pclk), .presetn(presetn), .lnk(lnk));
   psm_check i_psm_check (.pclk(pclk), .presetn(presetn), .sleep_stop_control_reg_wr(lnk.sleep_stop_control_reg_wr),
      .wr_byte(lnk.wr_byte), .i_flag(lnk.i_flag), .wake(lnk.wake),
      .cpu_clk_en(lnk.cpu_clk_en), .sys_clk_en(lnk.sys_clk_en),
      .periph_clk_en(lnk.periph_clk_en), .main_osc_en(lnk.main_osc_en),
      .run_en(lnk.run_en), .mode(lnk.mode), .sleep_stop_control_reg(lnk.sleep_stop_control_reg), .ckctl(lnk.ckctl),
      .bit_cnt(lnk.bit_cnt), .resume(lnk.resume), .vector_irq(lnk.vector_irq),
      .int_reset(lnk.int_reset));

   // Free-running 50 MHz clock
   always #10 pclk = ~pclk;

   // One APB transfer; an idle edge after it keeps strobes from toggling twice
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Poll status until the mode shows; bounded so a hang still reports
   task automatic wait_mode(input psm_mode_t m);
      int n;
      n = 0;
      do
      begin
         apb(A_STAT, 1'b0, 32'h0);
         n++;
      end
      while (rd[5:4] !== m && n < 600);
      chk({30'h0, rd[5:4]}, {30'h0, m});
   endtask

   task automatic enter_stop(input logic [7:0] ck, input logic [7:0] c);
      apb(A_CKCTL, 1'b1, {24'h0, ck});
      apb(A_CTRL, 1'b1, {24'h0, c});
      apb(A_SLEEP_STOP_CONTROL_REG, 1'b1, {24'h0, STOP_CODE});
      apb(A_CTRL, 1'b1, {24'h0, c | 8'h01});
      repeat (2) @(posedge pclk);
      wait_mode(PM_STOP);
   endtask

   // Reads the sticky events, compares, then clears them
   task automatic chk_evt(input logic [31:0] exp);
      apb(A_EVT, 1'b0, 32'h0);
      chk(rd & 32'hF, exp);
      apb(A_EVT, 1'b1, 32'hF);
   endtask

   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      fail_count = 0;
      n_compared = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(A_STAT, 1'b0, 32'h0);
      chk(rd & 32'hFF3F, 32'hFF0F);
      apb(8'h1C, 1'b0, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Odd code with upper junk: byte kept, stop and run-mode wake ignored
      apb(A_SLEEP_STOP_CONTROL_REG, 1'b1, 32'hFFFF_FF33);
      apb(A_IEN, 1'b1, 32'h7F);
      apb(A_CTRL, 1'b1, 32'h01);
      apb(A_WAKE, 1'b1, 32'h40);
      apb(A_SLEEP_STOP_CONTROL_REG, 1'b0, 32'h0);
      chk(rd, 32'h33);
      wait_mode(PM_RUN);
      for (int f = 0; f < 2; f++)
      begin
         apb(A_CTRL, 1'b1, f ? 32'h02 : 32'h00);
         apb(A_SLEEP_STOP_CONTROL_REG, 1'b1, {24'h0, SLEEP_CODE});
         wait_mode(PM_SLEEP);
         chk(rd & 32'h2F3F, 32'h091E);
         apb(A_IEN, 1'b1, 32'h00);
         apb(A_WAKE, 1'b1, 32'h40);
         wait_mode(PM_SLEEP);
         apb(A_IEN, 1'b1, 32'h7F);
         apb(A_WAKE, 1'b1, 32'h40);
         wait_mode(PM_RUN);
         chk_evt(f ? 32'h2 : 32'h1);
         apb(A_SLEEP_STOP_CONTROL_REG, 1'b0, 32'h0);
         chk(rd, 32'h0F);
      end
      // Every qualified stop wake source, after a refused one
      foreach (wsrc[i])
      begin
         enter_stop(8'h00, 8'h78);
         chk(rd & 32'h2B3F, 32'h0020);
         apb(A_WAKE, 1'b1, 32'h40);
         wait_mode(PM_STOP);
         apb(A_WAKE, 1'b1, 32'h1 << wsrc[i]);
         wait_mode(PM_WARM);
         wait_mode(PM_RUN);
         chk_evt(32'h1);
      end
      apb(A_CKCTL, 1'b0, 32'h0);
      chk(rd, 32'h00);
      // RC variant: watch refused, watchdog vectors, then resets
      enter_stop(8'h22, 8'h16);
      chk(rd & 32'h0330, 32'h0320);
      apb(A_WAKE, 1'b1, 32'h08);
      wait_mode(PM_STOP);
      apb(A_WAKE, 1'b1, 32'h04);
      wait_mode(PM_RUN);
      chk_evt(32'h4);
      enter_stop(8'h30, 8'h16);
      apb(A_WAKE, 1'b1, 32'h04);
      wait_mode(PM_RUN);
      chk_evt(32'h8);
      apb(A_CKCTL, 1'b0, 32'h0);
      chk(rd, 32'h00);
      // Pin reset in mid-stop returns to the main active mode
      enter_stop(8'h00, 8'h00);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(A_STAT, 1'b0, 32'h0);
      chk(rd & 32'h3F, 32'h0F);
      apb(A_SLEEP_STOP_CONTROL_REG, 1'b0, 32'h0);
      chk(rd, 32'h00);
      test_done();
   end

   // Watchdog: the tests need a few thousand cycles
   initial
   begin
      #400_000;
      fail_count++;
      test_done();
   end
endmodule
`default_nettype wire
